//--- verilog/msl_pkg.sv
// Package for the muting safety logic: timing, register map, carriers.
// Assumes a 100 MHz hclk and an AHB-Lite register bus.
package msl_pkg;
   // Clock period in ns
   localparam int unsigned CLK_PERIOD_NS = 10;
   // Simultaneity window for two-channel inputs, in ms
   localparam int unsigned SIMUL_MS = 3000;
   localparam int unsigned SIMUL_CYC = SIMUL_MS * 1000000 / CLK_PERIOD_NS;
   // Maximum muting time, in ms
   localparam int unsigned MUTE_MAX_MS = 30000;
   localparam int unsigned MUTE_MAX_CYC = MUTE_MAX_MS * 100000;
   // Lamp switch-on bridging time, in ms
   localparam int unsigned LAMP_BRIDGE_MS = 100;
   localparam int unsigned LAMP_BRIDGE_CYC = LAMP_BRIDGE_MS * 1000000 / CLK_PERIOD_NS;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
   // Control bit positions and reset values
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [5:0] IRQ_MASK_RESET = 6'h00;
   // Interrupt event bit positions
   localparam int unsigned EV_MUTE_START = 0;
   localparam int unsigned EV_MUTE_TIMEOUT = 1;
   localparam int unsigned EV_LAMP_FAULT = 2;
   localparam int unsigned EV_SIMUL_ERR = 3;
   localparam int unsigned EV_MOTOR_OFF = 4;
   localparam int unsigned EV_GUARD_BREAK = 5;
   localparam int unsigned EV_N = 6;

   // Field inputs after synchronisation
   typedef struct packed {
      logic guard_a;
      logic guard_b;
      logic muting_sensor_a1;
      logic muting_sensor_a2;
      logic muting_sensor_b1;
      logic muting_sensor_b2;
      logic lamp_mon_a;
      logic lamp_mon_b;
      logic feedback_ok;
      logic continue_btn;
      logic motor_start;
   } msl_field_t;

   // Two-channel evaluator states
   typedef enum logic [1:0] {
      TC_OFF = 2'b00,
      TC_WAIT = 2'b01,
      TC_ON = 2'b11,
      TC_LOCK = 2'b10
   } msl_tc_state_t;
endpackage

//--- verilog/msl_two_chan.sv
// Two-channel input evaluator with simultaneity window and auto reset.
// Inputs are already synchronised to hclk.
`timescale 1ns/1ps
module msl_two_chan
   import msl_pkg::*;
#(
   parameter int unsigned WINDOW_CYC = SIMUL_CYC
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Channels, active high
   input wire logic chan_a,
   input wire logic chan_b,
   // Result
   output logic active,
   output logic simul_err
);
   msl_tc_state_t state_ff;
   logic [31:0] cnt_ff;

   // Both on: active. One on: wait. Window over: lock until both off.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= TC_OFF;
         cnt_ff <= 32'h0;
      end else begin
         case (state_ff)
            TC_OFF: begin
               cnt_ff <= 32'h0;
               if (chan_a && chan_b) state_ff <= TC_ON;
               else if (chan_a || chan_b) state_ff <= TC_WAIT;
            end
            TC_WAIT: begin
               cnt_ff <= cnt_ff + 32'h1;
               if (chan_a && chan_b) state_ff <= TC_ON;
               else if (!chan_a && !chan_b) state_ff <= TC_OFF;
               else if (cnt_ff >= WINDOW_CYC - 1) state_ff <= TC_LOCK;
            end
            TC_ON: begin
               if (!chan_a || !chan_b) state_ff <= TC_LOCK;
            end
            TC_LOCK: begin
               // Automatic reset once both channels return to idle
               if (!chan_a && !chan_b) state_ff <= TC_OFF;
            end
            default: state_ff <= TC_OFF;
         endcase
      end
   end

   // Half-open channel after ON needs a full off before re-arming
   assign active = (state_ff == TC_ON);
   assign simul_err = (state_ff == TC_WAIT) && (cnt_ff >= WINDOW_CYC - 1)
      && !(chan_a && chan_b) && (chan_a || chan_b);
endmodule

//--- verilog/msl_top.sv
// Muting safety logic: light guard, four muting sensors, monitored lamp,
// latched redundant motor output, AHB-Lite registers and interrupt.
// Field pins are asynchronous; the bus runs on hclk.
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module msl_top
   import msl_pkg::*;
#(
   parameter int unsigned SIMUL_CYC_P = SIMUL_CYC,
   parameter int unsigned MUTE_MAX_CYC_P = MUTE_MAX_CYC,
   parameter int unsigned LAMP_BRIDGE_CYC_P = LAMP_BRIDGE_CYC
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Field inputs, asynchronous
   input wire logic [10:0] field_pins,
   // Field outputs
   output logic motor_out_a,
   output logic motor_out_b,
   output logic muting_lamp,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers: three stages, change taken when 2nd and 3rd agree
   logic [10:0] sync1_ff;
   logic [10:0] sync2_ff;
   logic [10:0] sync3_ff;
   logic [10:0] filt_ff;
   msl_field_t fld;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_ff <= 11'h0;
         sync2_ff <= 11'h0;
         sync3_ff <= 11'h0;
         filt_ff <= 11'h0;
      end else begin
         sync1_ff <= field_pins;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         for (int i = 0; i < 11; i++) begin
            if (sync2_ff[i] == sync3_ff[i]) filt_ff[i] <= sync3_ff[i];
         end
      end
   end
   assign fld = msl_field_t'(filt_ff);

   ////////////////////////////////////////////////////////////////////////
   // Two-channel evaluation of sensor pairs, guard and lamp monitor
   logic pair_a_on;
   logic pair_b_on;
   logic guard_clear;
   logic lamp_ok;
   logic err_a;
   logic err_b;
   logic err_g;
   logic err_l;

   msl_two_chan #(.WINDOW_CYC(SIMUL_CYC_P)) u_pair_a (
      .hclk(hclk), .hresetn(hresetn),
      .chan_a(fld.muting_sensor_a1), .chan_b(fld.muting_sensor_a2),
      .active(pair_a_on), .simul_err(err_a)
   );
   msl_two_chan #(.WINDOW_CYC(SIMUL_CYC_P)) u_pair_b (
      .hclk(hclk), .hresetn(hresetn),
      .chan_a(fld.muting_sensor_b1), .chan_b(fld.muting_sensor_b2),
      .active(pair_b_on), .simul_err(err_b)
   );
   // Light guard, two NC channels, high means clear
   msl_two_chan #(.WINDOW_CYC(SIMUL_CYC_P)) u_guard (
      .hclk(hclk), .hresetn(hresetn),
      .chan_a(fld.guard_a), .chan_b(fld.guard_b),
      .active(guard_clear), .simul_err(err_g)
   );
   msl_two_chan #(.WINDOW_CYC(SIMUL_CYC_P)) u_lamp (
      .hclk(hclk), .hresetn(hresetn),
      .chan_a(fld.lamp_mon_a), .chan_b(fld.lamp_mon_b),
      .active(lamp_ok), .simul_err(err_l)
   );

   ////////////////////////////////////////////////////////////////////////
   // Muting request and maximum muting timer
   logic mute_req;
   logic mute_ff;
   logic mute_expired_ff;
   logic [31:0] mute_cnt_ff;
   logic cont_prev_ff;
   logic cont_edge;

   // either pair active mutes, serves both arrangements
   assign mute_req = pair_a_on || pair_b_on;
   assign cont_edge = fld.continue_btn && !cont_prev_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mute_ff <= 1'b0;
         mute_expired_ff <= 1'b0;
         mute_cnt_ff <= 32'h0;
         cont_prev_ff <= 1'b0;
      end else begin
         cont_prev_ff <= fld.continue_btn;
         if (!mute_req) begin
            mute_ff <= 1'b0;
            mute_expired_ff <= 1'b0;
            mute_cnt_ff <= 32'h0;
         end else if (cont_edge) begin
            mute_ff <= 1'b1;
            mute_expired_ff <= 1'b0;
            mute_cnt_ff <= 32'h0;
         end else if (!mute_expired_ff) begin
            if (mute_cnt_ff >= MUTE_MAX_CYC_P - 1) begin
               mute_ff <= 1'b0;
               mute_expired_ff <= 1'b1;
            end else begin
               mute_ff <= 1'b1;
               mute_cnt_ff <= mute_cnt_ff + 32'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lamp drive and bridging delay
   logic [31:0] bridge_cnt_ff;
   logic bridge_done;
   logic lamp_fault;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) bridge_cnt_ff <= 32'h0;
      else if (!mute_ff) bridge_cnt_ff <= 32'h0;
      else if (!bridge_done) bridge_cnt_ff <= bridge_cnt_ff + 32'h1;
   end
   assign bridge_done = (bridge_cnt_ff >= LAMP_BRIDGE_CYC_P);
   // lamp monitor low is a fault
   assign lamp_fault = mute_ff && bridge_done && !lamp_ok;

   // lamp on auxiliary output, follows muting
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) muting_lamp <= 1'b0;
      else muting_lamp <= mute_ff;
   end

   ////////////////////////////////////////////////////////////////////////
   // Motor latch and redundant output
   logic run_en_ff;
   logic enable_ok;
   logic motor_ff;
   logic stop_req;

   // Run permission: guard clear or valid muting, no lamp fault, CTRL run bit set
   assign enable_ok = (guard_clear || mute_ff) && !lamp_fault && run_en_ff;
   // Any lost permission stops the motor
   assign stop_req = !enable_ok;

   // RS latch, reset dominant, start needs closed feedback
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) motor_ff <= 1'b0;
      else if (stop_req) motor_ff <= 1'b0;
      else if (fld.motor_start && fld.feedback_ok) motor_ff <= 1'b1;
   end

   assign motor_out_a = motor_ff;
   assign motor_out_b = motor_ff;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt events
   logic [EV_N-1:0] ev;
   logic [EV_N-1:0] irq_stat_ff;
   logic [EV_N-1:0] irq_mask_ff;
   logic mute_prev_ff;
   logic motor_prev_ff;
   logic guard_prev_ff;
   logic [EV_N-1:0] w1c;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mute_prev_ff <= 1'b0;
         motor_prev_ff <= 1'b0;
         guard_prev_ff <= 1'b0;
      end else begin
         mute_prev_ff <= mute_ff;
         motor_prev_ff <= motor_ff;
         guard_prev_ff <= guard_clear;
      end
   end

   always_comb begin
      ev = '0;
      ev[EV_MUTE_START] = mute_ff && !mute_prev_ff;
      ev[EV_MUTE_TIMEOUT] = mute_prev_ff && !mute_ff && mute_expired_ff;
      ev[EV_LAMP_FAULT] = lamp_fault;
      ev[EV_SIMUL_ERR] = err_a || err_b || err_g || err_l;
      ev[EV_MOTOR_OFF] = motor_prev_ff && !motor_ff;
      ev[EV_GUARD_BREAK] = guard_prev_ff && !guard_clear;
   end

   // Sticky status, set wins over write-one-clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) irq_stat_ff <= '0;
      else irq_stat_ff <= (irq_stat_ff & ~w1c) | ev;
   end
   assign irq = |(irq_stat_ff & irq_mask_ff);

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states
   logic ap_valid_ff;
   logic ap_write_ff;
   logic [7:0] ap_addr_ff;
   logic ap_take;

   assign ap_take = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_ff <= 1'b0;
         ap_write_ff <= 1'b0;
         ap_addr_ff <= 8'h00;
      end else if (hready) begin
         ap_valid_ff <= ap_take;
         ap_write_ff <= hwrite;
         ap_addr_ff <= haddr[7:0];
      end
   end

   // Software writes
   assign w1c = (ap_valid_ff && ap_write_ff && ap_addr_ff == OFS_IRQ_STAT)
      ? hwdata[EV_N-1:0] : '0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_en_ff <= CTRL_RESET[CTRL_RUN_BIT];
         irq_mask_ff <= IRQ_MASK_RESET;
      end else if (ap_valid_ff && ap_write_ff) begin
         if (ap_addr_ff == OFS_CTRL) run_en_ff <= hwdata[CTRL_RUN_BIT];
         if (ap_addr_ff == OFS_IRQ_MASK) irq_mask_ff <= hwdata[EV_N-1:0];
      end
   end

   // Read data registered in address phase; unmapped reads as zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hrdata <= 32'h0;
      else if (ap_take && !hwrite) begin
         case (haddr[7:0])
            OFS_CTRL: hrdata <= {31'h0, run_en_ff};
            OFS_STATUS: hrdata <= {24'h0, lamp_ok, guard_clear, pair_b_on,
               pair_a_on, mute_expired_ff, mute_ff, muting_lamp, motor_ff};
            OFS_IRQ_STAT: hrdata <= {26'h0, irq_stat_ff};
            OFS_IRQ_MASK: hrdata <= {26'h0, irq_mask_ff};
            default: hrdata <= 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   // channels never differ
   property p_chan_equal;
      @(posedge hclk) disable iff (!hresetn) motor_out_a == motor_out_b;
   endproperty
   a_chan_equal: assert property (p_chan_equal) else $error("motor channels differ");
   property p_start_fb;
      @(posedge hclk) disable iff (!hresetn)
         $rose(motor_ff) |-> $past(fld.feedback_ok);
   endproperty
   a_start_fb: assert property (p_start_fb) else $error("motor started open loop");
   // lamp fault drops motor next cycle
   property p_lamp_stop;
      @(posedge hclk) disable iff (!hresetn) lamp_fault |=> !motor_ff;
   endproperty
   a_lamp_stop: assert property (p_lamp_stop) else $error("lamp fault kept motor");
   // switch-on bridged for at least eight cycles
   property p_bridge;
      @(posedge hclk) disable iff (!hresetn) $rose(mute_ff) |-> !lamp_fault [*8];
   endproperty
   a_bridge: assert property (p_bridge) else $error("lamp fault in bridge");
   // lamp follows muting by one cycle
   property p_lamp_out;
      @(posedge hclk) disable iff (!hresetn) ##1 muting_lamp == $past(mute_ff);
   endproperty
   a_lamp_out: assert property (p_lamp_out) else $error("lamp not tracking muting");
   property p_expire;
      @(posedge hclk) disable iff (!hresetn) mute_expired_ff |-> !mute_ff;
   endproperty
   a_expire: assert property (p_expire) else $error("muting beyond timer");
   property p_cont;
      @(posedge hclk) disable iff (!hresetn)
         (mute_req && cont_edge) |=> (mute_ff && mute_cnt_ff == 32'h0);
   endproperty
   a_cont: assert property (p_cont) else $error("continue did not restart");
   property p_mute_src;
      @(posedge hclk) disable iff (!hresetn) mute_ff |-> $past(mute_req);
   endproperty
   a_mute_src: assert property (p_mute_src) else $error("muting without sensors");
endmodule

//--- sim/msl_field_model.sv
// Field side: monitored muting lamp and the two motor contactors.
// Assumes device outputs change on hclk; no reset, starts de-energised.
`timescale 1ns/1ps
module msl_field_model (
   // Clock
   input wire logic hclk,
   // Device outputs
   input wire logic motor_out_a,
   input wire logic motor_out_b,
   input wire logic muting_lamp,
   // Fault commands from the bench
   input wire logic lamp_broken,
   input wire logic contact_weld,
   // Returns to the device
   output logic lamp_mon_a,
   output logic lamp_mon_b,
   output logic feedback_ok
);
   logic [2:0] lamp_ff = 3'h0;
   logic [1:0] coil_ff = 2'h0;
   ////////////////////////////////////////////////////////////////////////////
   // lamp warm-up
   // Lamp needs three cycles to light, shorter than the bridge
   always_ff @(posedge hclk) begin
      lamp_ff <= {lamp_ff[1:0], muting_lamp};
      coil_ff <= {coil_ff[0], motor_out_a & motor_out_b};
   end
   // lamp monitor
   // A dead filament opens both monitor loops at once
   assign lamp_mon_a = lamp_ff[2] & ~lamp_broken;
   assign lamp_mon_b = lamp_ff[2] & ~lamp_broken;
   // contactor feedback
   // Break contacts open two cycles after the coils pull in
   // A welded contact holds the loop open
   assign feedback_ok = ~coil_ff[1] & ~contact_weld;
endmodule

//--- sim/test_muting_safety_logic.sv
// Self-checking bench for the muting safety logic with a field model.
// Assumes msl_top with short counts: window 20, muting 200, bridge 10.
`timescale 1ns/1ps
module test_muting_safety_logic import msl_pkg::*;;
   typedef struct packed {logic [31:0] m; logic [31:0] v; logic bus;} msl_exp_t;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, got;
   logic hreadyout, hresp, motor_out_a, motor_out_b, muting_lamp, irq;
   logic guard = 1'b1;
   logic [3:0] sens = 4'h0;
   logic cont = 1'b0;
   logic start = 1'b0;
   logic lamp_broken = 1'b0;
   logic weld = 1'b0;
   logic mon_a, mon_b, fb;
   logic rd_pend = 1'b0;
   logic pin_pend = 1'b0;
   msl_exp_t e;
   msl_exp_t expq[$];
   int err_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   int seed = 84;
   int gap;

   msl_top #(.SIMUL_CYC_P(20), .MUTE_MAX_CYC_P(200), .LAMP_BRIDGE_CYC_P(10)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .field_pins({guard, guard, sens, mon_a, mon_b, fb, cont, start}),
      .motor_out_a(motor_out_a), .motor_out_b(motor_out_b),
      .muting_lamp(muting_lamp), .irq(irq));
   msl_field_model u_field (.hclk(hclk), .motor_out_a(motor_out_a),
      .motor_out_b(motor_out_b), .muting_lamp(muting_lamp), .lamp_broken(lamp_broken),
      .contact_weld(weld), .lamp_mon_a(mon_a), .lamp_mon_b(mon_b), .feedback_ok(fb));

   always #5 hclk = ~hclk;
   ////////////////////////////////////////////////////////////////////////////
   // Oldest note against the result that has just appeared
   always @(posedge hclk) begin
      if ((rd_pend && hreadyout) || pin_pend) begin
         e = expq.pop_front();
         got = e.bus ? hrdata : {28'h0, irq, muting_lamp, motor_out_b, motor_out_a};
         samples_checked++;
         if ((got & e.m) !== e.v || hresp !== 1'b0) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got & e.m, e.v);
         end
      end
      if (hresetn && motor_out_a !== motor_out_b) begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, motor_out_b, motor_out_a);
      end
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Single word transfer; a read notes its masked expectation
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      if (!wr) begin
         expq.push_back('{m, d & m, 1'b1});
         rd_pend <= 1'b1;
      end
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_pend <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      bus(1'b0, a, v, m);
   endtask
   // Pins as {irq, lamp, motor b, motor a}
   task automatic pins(input logic [3:0] m, input logic [3:0] v);
      @(posedge hclk);
      expq.push_back('{{28'h0, m}, {28'h0, v & m}, 1'b0});
      pin_pend <= 1'b1;
      @(posedge hclk);
      pin_pend <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic field(input logic g, input logic [3:0] s);
      @(posedge hclk);
      guard <= g;
      sens <= s;
   endtask
   // Pulses outlast the four-edge input filter
   task automatic pulse(input logic btn);
      @(posedge hclk);
      if (btn) start <= 1'b1; else cont <= 1'b1;
      idle(6);
      start <= 1'b0;
      cont <= 1'b0;
      idle(6);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      idle(4);
      hresetn <= 1'b1;
      idle(8);
      rd(OFS_CTRL, 32'hffffffff, CTRL_RESET);
      rd(OFS_IRQ_MASK, 32'hffffffff, 32'h0);
      wr(8'h10, 32'hffffffff);
      rd(8'h10, 32'hffffffff, 32'h0);
      pulse(1'b1);
      pins(4'h3, 4'h0);
      wr(OFS_CTRL, 32'h1);
      pulse(1'b1);
      pins(4'h3, 4'h3);
      $display("test start done");
      wr(OFS_IRQ_MASK, 32'h1 << EV_GUARD_BREAK);
      field(1'b0, 4'h0);
      idle(8);
      pins(4'hb, 4'h8);
      rd(OFS_IRQ_STAT, 32'h1 << EV_GUARD_BREAK, 32'h1 << EV_GUARD_BREAK);
      field(1'b1, 4'h0);
      idle(8);
      wr(OFS_IRQ_STAT, 32'h3f);
      pins(4'h8, 4'h0);
      $display("test guard done");
      pulse(1'b1);
      field(1'b1, 4'hc);
      idle(8);
      field(1'b0, 4'hc);
      idle(30);
      pins(4'h7, 4'h7);
      field(1'b0, 4'hf);
      idle(8);
      field(1'b0, 4'h3);
      idle(8);
      pins(4'h7, 4'h7);
      field(1'b1, 4'h0);
      idle(8);
      pins(4'h7, 4'h3);
      $display("test muting done");
      field(1'b1, 4'hc);
      idle(6);
      field(1'b0, 4'hc);
      idle(170);
      pins(4'h3, 4'h3);
      idle(40);
      pins(4'h3, 4'h0);
      rd(OFS_STATUS, 32'hc, 32'h8);
      rd(OFS_IRQ_STAT, 32'h13, 32'h13);
      pulse(1'b0);
      rd(OFS_STATUS, 32'hc, 32'h4);
      pulse(1'b1);
      idle(120);
      pins(4'h7, 4'h7);
      field(1'b1, 4'h0);
      idle(8);
      $display("test timer done");
      wr(OFS_IRQ_MASK, 32'h1 << EV_LAMP_FAULT);
      field(1'b1, 4'h3);
      idle(30);
      pins(4'h9, 4'h1);
      lamp_broken <= 1'b1;
      idle(10);
      pins(4'hb, 4'h8);
      rd(OFS_IRQ_STAT, 32'h1 << EV_LAMP_FAULT, 32'h1 << EV_LAMP_FAULT);
      lamp_broken <= 1'b0;
      field(1'b1, 4'h0);
      idle(10);
      wr(OFS_IRQ_STAT, 32'h3f);
      pins(4'h8, 4'h0);
      weld <= 1'b1;
      idle(4);
      pulse(1'b1);
      pins(4'h3, 4'h0);
      weld <= 1'b0;
      $display("test lamp done");
      field(1'b1, 4'h8);
      idle(40);
      field(1'b1, 4'hc);
      idle(8);
      rd(OFS_STATUS, 32'h10, 32'h0);
      rd(OFS_IRQ_STAT, 32'h8, 32'h8);
      field(1'b1, 4'h0);
      idle(8);
      // Random skew inside the window, alternating pairs
      for (int i = 0; i < 6; i++) begin
         gap = $unsigned($random(seed)) % 12;
         field(1'b1, i[0] ? 4'h2 : 4'h8);
         idle(gap);
         field(1'b1, i[0] ? 4'h3 : 4'hc);
         idle(8);
         rd(OFS_STATUS, 32'h34, i[0] ? 32'h24 : 32'h14);
         field(1'b1, 4'h0);
         idle(8);
      end
      $display("test simultaneity done");
      conclude();
   end
endmodule
